// ==== common/uth_pkg.sv ====
// Shared constants for the host-mode transmit endpoint control block.
// Assumes a 32-bit APB with word-aligned registers; a printed offset is an index.
package uth_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CSRH = 10'h113;
  localparam logic [9:0] IDX_TXCTL = 10'h110;
  localparam logic [9:0] IDX_MAXP = 10'h114;
  localparam logic [9:0] IDX_FILL = 10'h115;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h118;
  localparam logic [9:0] IDX_IRQ_EN = 10'h119;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h11a;

  // Control high byte field positions
  localparam int B_AUTO = 7;
  localparam int B_RSVD = 6;
  localparam int B_MODE = 5;
  localparam int B_DMA_REQUEST_ENABLE = 4;
  localparam int B_FORCE = 3;
  localparam int B_DMA_INTERRUPT_MODE = 2;
  localparam int B_TWE = 1;
  localparam int B_TOGGLE = 0;

  // Transmit control register field positions
  localparam int B_READY = 0;
  localparam int B_SHARED = 1;

  // Interrupt status field positions
  localparam int B_EV_SENT = 0;
  localparam int B_EV_DMA = 1;
  localparam int B_EV_FORCE = 2;
  localparam int EV_W = 3;

  // Widths and reset values
  localparam int MAXP_W = 11;
  localparam logic [7:0] CSRH_RST = 8'h00;
  localparam logic [MAXP_W-1:0] MAXP_RST = 11'h040;
  localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h0;

endpackage : uth_pkg

// ==== hdl/uth_ctrl_high.sv ====
// Host-mode transmit endpoint control high byte with its APB slave.
// Assumes APB signals and endpoint strobes are synchronous to clk.
// Operation
// - With auto-ready set, a full max-size packet sets packet-ready by itself.
// - Bit 6 is reserved, reads zero, writes are dropped.
// - Direction bit: zero receive, one transmit.
// - Direction matters only when the endpoint FIFO is shared.
// - DMA request enable gates the endpoint's DMA request line.
// - Writing one to force-toggle flips the toggle and flushes the packet.
// - DMA interrupt mode: zero per packet, one at whole transfer end.
// - Toggle write needs write-enable high; enable clears after the write.
// - Reading the toggle bit returns the present data toggle.
// - Toggle writes with write-enable low are ignored.
// - Register at index 0x113, all fields reset to zero.
// - Software sets packet-ready after loading; hardware clears it once sent.
module uth_ctrl_high (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fifo_byte_load,
  input wire logic pkt_acked,
  input wire logic dma_pkt_done,
  input wire logic dma_xfer_done,
  output logic tx_packet_ready,
  output logic fifo_flush,
  output logic dma_req,
  output logic dir_tx,
  output logic data_toggle,
  output logic irq
);

  // Byte address of a register index
  function automatic logic [11:0] addr_of(input logic [9:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

  // Stored control fields
  logic auto_ready_on_full_packet_r;
  logic mode_tx_r;
  logic dma_request_enable_r;
  logic dma_interrupt_mode_r;
  logic data_toggle_state_r;
  logic data_toggle_state_nxt;
  logic tx_packet_ready_r;
  logic tx_packet_ready_nxt;
  logic shared_fifo_r;
  logic [uth_pkg::MAXP_W-1:0] tx_max_packet_size_r;
  logic [uth_pkg::EV_W-1:0] irq_en_r;

  // Bus-side and endpoint-facing output registers
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic flush_r;
  logic dma_req_r;
  logic dir_tx_r;

  // Decode
  logic access;
  logic wr_en;
  logic rd_en;
  logic sel_csrh;
  logic sel_txctl;
  logic sel_maxp;
  logic sel_fill;
  logic sel_stat;
  logic sel_en;
  logic sel_clr;
  logic mapped;
  logic wr_csrh;
  logic wr_txctl;

  // Endpoint events and helpers
  logic force_flip;
  logic toggle_wr;
  logic full_pulse;
  logic dma_event;
  logic sw_ready_set;
  logic [uth_pkg::MAXP_W-1:0] fill_count;
  logic [uth_pkg::EV_W-1:0] irq_status;
  logic [uth_pkg::EV_W-1:0] irq_events;
  logic [uth_pkg::EV_W-1:0] irq_clear;
  logic [7:0] csrh_view;
  logic [31:0] rd_mux;

  // One wait state: the access phase completes when registered pready is high
  assign access = psel && penable && pready_r;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;

  // Address decode on the full word address
  assign sel_csrh = (paddr == addr_of(uth_pkg::IDX_CSRH));
  assign sel_txctl = (paddr == addr_of(uth_pkg::IDX_TXCTL));
  assign sel_maxp = (paddr == addr_of(uth_pkg::IDX_MAXP));
  assign sel_fill = (paddr == addr_of(uth_pkg::IDX_FILL));
  assign sel_stat = (paddr == addr_of(uth_pkg::IDX_IRQ_STAT));
  assign sel_en = (paddr == addr_of(uth_pkg::IDX_IRQ_EN));
  assign sel_clr = (paddr == addr_of(uth_pkg::IDX_IRQ_CLR));
  assign mapped = sel_csrh | sel_txctl | sel_maxp | sel_fill |
                  sel_stat | sel_en | sel_clr;
  assign wr_csrh = wr_en && sel_csrh;
  assign wr_txctl = wr_en && sel_txctl;

  // Force-toggle is a self-clearing strobe, it never stays set
  assign force_flip = wr_csrh && pwdata[uth_pkg::B_FORCE];
  // Toggle value is accepted only with write-enable set in the same write
  assign toggle_wr = wr_csrh && pwdata[uth_pkg::B_TWE];

  // A directed write sets the value; a forced flip inverts whatever results
  assign data_toggle_state_nxt =
    (toggle_wr ? pwdata[uth_pkg::B_TOGGLE] :
     pkt_acked ? !data_toggle_state_r : data_toggle_state_r)
    ^ force_flip;

  // Software set of packet-ready through the transmit control register
  assign sw_ready_set = wr_txctl && pwdata[uth_pkg::B_READY];

  // Clears first, then sets, so a set landing with a clear is kept
  assign tx_packet_ready_nxt =
    ((tx_packet_ready_r && !pkt_acked && !force_flip)
     || sw_ready_set
     || (auto_ready_on_full_packet_r && full_pulse));

  // DMA interrupt event chosen by the interrupt mode bit
  assign dma_event = dma_interrupt_mode_r ? dma_xfer_done : dma_pkt_done;

  assign irq_events[uth_pkg::B_EV_SENT] = pkt_acked && tx_packet_ready_r;
  assign irq_events[uth_pkg::B_EV_DMA] = dma_event;
  assign irq_events[uth_pkg::B_EV_FORCE] = force_flip;
  assign irq_clear = (wr_en && sel_clr) ? pwdata[uth_pkg::EV_W-1:0] : '0;

  // Read view of the control high byte; write-enable never reads back set
  // because it clears in the same cycle as the toggle write it permits.
  assign csrh_view = {auto_ready_on_full_packet_r,
                      1'b0,
                      mode_tx_r,
                      dma_request_enable_r,
                      1'b0,
                      dma_interrupt_mode_r,
                      1'b0,
                      data_toggle_state_r};

  // Read data mux; unmapped addresses read zero
  assign rd_mux =
    sel_csrh ? {24'h000000, csrh_view} :
    sel_txctl ? {30'h0, shared_fifo_r, tx_packet_ready_r} :
    sel_maxp ? {21'h0, tx_max_packet_size_r} :
    sel_fill ? {21'h0, fill_count} :
    sel_stat ? {29'h0, irq_status} :
    sel_en ? {29'h0, irq_en_r} : 32'h00000000;

  // Byte counter for the packet in the FIFO, restarted by a flush
  uth_fill_count u_fill (
    .clk(clk),
    .rst_n(rst_n),
    .load(fifo_byte_load),
    .clear(force_flip),
    .max_size(tx_max_packet_size_r),
    .count(fill_count),
    .full_pulse(full_pulse)
  );

  // Sticky endpoint events onto one level interrupt
  uth_irq u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .events(irq_events),
    .clear(irq_clear),
    .enable(irq_en_r),
    .status(irq_status),
    .irq(irq)
  );

  // APB handshake: pready rises for the second access cycle, drops after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      prdata_r <= (psel && penable && !pready_r && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Control high byte fields, zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_ready_on_full_packet_r <= uth_pkg::CSRH_RST[uth_pkg::B_AUTO];
      mode_tx_r <= uth_pkg::CSRH_RST[uth_pkg::B_MODE];
      dma_request_enable_r <= uth_pkg::CSRH_RST[uth_pkg::B_DMA_REQUEST_ENABLE];
      dma_interrupt_mode_r <= uth_pkg::CSRH_RST[uth_pkg::B_DMA_INTERRUPT_MODE];
    end else if (wr_csrh) begin
      auto_ready_on_full_packet_r <= pwdata[uth_pkg::B_AUTO];
      mode_tx_r <= pwdata[uth_pkg::B_MODE];
      dma_request_enable_r <= pwdata[uth_pkg::B_DMA_REQUEST_ENABLE];
      dma_interrupt_mode_r <= pwdata[uth_pkg::B_DMA_INTERRUPT_MODE];
    end
  end

  // Data toggle and packet-ready state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_toggle_state_r <= uth_pkg::CSRH_RST[uth_pkg::B_TOGGLE];
      tx_packet_ready_r <= 1'b0;
    end else begin
      data_toggle_state_r <= data_toggle_state_nxt;
      tx_packet_ready_r <= tx_packet_ready_nxt;
    end
  end

  // Own configuration: shared FIFO flag, max packet size, interrupt enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_fifo_r <= 1'b0;
      tx_max_packet_size_r <= uth_pkg::MAXP_RST;
      irq_en_r <= uth_pkg::IRQ_EN_RST;
    end else begin
      if (wr_txctl) shared_fifo_r <= pwdata[uth_pkg::B_SHARED];
      if (wr_en && sel_maxp) tx_max_packet_size_r <= pwdata[uth_pkg::MAXP_W-1:0];
      if (wr_en && sel_en) irq_en_r <= pwdata[uth_pkg::EV_W-1:0];
    end
  end

  // Endpoint-facing outputs, all registered.
  // A dedicated transmit FIFO always faces transmit, whatever the mode bit says.
  // DMA asks for data only while no packet waits, so the FIFO is not overrun.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_r <= 1'b0;
      dma_req_r <= 1'b0;
      dir_tx_r <= 1'b1;
    end else begin
      flush_r <= force_flip;
      dir_tx_r <= shared_fifo_r ? mode_tx_r : 1'b1;
      dma_req_r <= dma_request_enable_r && dir_tx_r && !tx_packet_ready_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_packet_ready = tx_packet_ready_r;
  assign fifo_flush = flush_r;
  assign dma_req = dma_req_r;
  assign dir_tx = dir_tx_r;
  assign data_toggle = data_toggle_state_r;

endmodule : uth_ctrl_high

// ==== hdl/uth_fill_count.sv ====
// Byte counter for the packet being loaded into the transmit FIFO.
// Assumes one load strobe per byte, synchronous to clk.
module uth_fill_count (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic clear,
  input wire logic [uth_pkg::MAXP_W-1:0] max_size,
  output logic [uth_pkg::MAXP_W-1:0] count,
  output logic full_pulse
);

  logic [uth_pkg::MAXP_W-1:0] count_r;
  logic [uth_pkg::MAXP_W-1:0] count_nxt;
  logic full_r;
  logic hit;

  // A full packet is reached on the byte that makes the count equal the limit
  assign hit = load && (max_size != '0) &&
               ((count_r + uth_pkg::MAXP_W'(1)) == max_size);
  assign count_nxt = clear ? '0 :
                     hit ? '0 :
                     load ? count_r + uth_pkg::MAXP_W'(1) : count_r;

  // Counter restarts after each full packet so the next one is counted afresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      full_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      full_r <= hit && !clear;
    end
  end

  assign count = count_r;
  assign full_pulse = full_r;

endmodule : uth_fill_count

// ==== hdl/uth_irq.sv ====
// Sticky interrupt status with enable mask and write-one-to-clear.
// Assumes event pulses and clear strobes are synchronous to clk.
module uth_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [uth_pkg::EV_W-1:0] events,
  input wire logic [uth_pkg::EV_W-1:0] clear,
  input wire logic [uth_pkg::EV_W-1:0] enable,
  output logic [uth_pkg::EV_W-1:0] status,
  output logic irq
);

  logic [uth_pkg::EV_W-1:0] stat_r;
  logic [uth_pkg::EV_W-1:0] stat_nxt;
  logic irq_r;

  // Set beats clear so an event landing on a clear write is kept
  assign stat_nxt = (stat_r & ~clear) | events;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & enable);
    end
  end

  assign status = stat_r;
  assign irq = irq_r;

endmodule : uth_irq

// ==== test/uth_ctrl_high_properties.sv ====
// Port-level checks of the control high byte and its APB slave.
// Assumes one clock domain and the package register map.
module uth_ctrl_high_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pkt_acked,
  input wire logic tx_packet_ready,
  input wire logic fifo_flush,
  input wire logic dma_req,
  input wire logic data_toggle
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CSRH = {uth_pkg::IDX_CSRH, 2'h0};
  // Completing write to the control high byte
  wire wr_c = psel && penable && pready && pwrite && paddr == A_CSRH;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence access_start;
    psel && $rose(penable);
  endsequence
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  sequence flush_pulse;
    fifo_flush ##1 !fifo_flush;
  endsequence
  wait_state_a: assert property (access_start |-> one_wait) else $error("wait state");
  ready_single_a: assert property (pready |=> !pready) else $error("pready held");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  csrh_mapped_a: assert property (pready && paddr == A_CSRH |-> !pslverr)
    else $error("csrh unmapped");
  force_flush_a: assert property (wr_c && pwdata[3] |=> flush_pulse)
    else $error("no flush");
  toggle_write_a: assert property (wr_c && pwdata[1] && !pwdata[3] |=>
    data_toggle == $past(pwdata[0])) else $error("toggle not written");
  toggle_hold_a: assert property (wr_c && !pwdata[1] && !pwdata[3] && !pkt_acked
    |=> $stable(data_toggle)) else $error("toggle changed");
  dma_gate_a: assert property (dma_req |-> !tx_packet_ready)
    else $error("dma req with ready");
endmodule : uth_ctrl_high_properties
bind uth_ctrl_high uth_ctrl_high_properties uth_ctrl_high_properties_i (.*);

// ==== test/uth_ctrl_high_tb_top.sv ====
// Self-checking bench: APB master, far-end model and bound checker.
// Assumes a 40 MHz clock; expectations come from package constants.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module uth_ctrl_high_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] A_CSRH = {uth_pkg::IDX_CSRH, 2'h0};
  localparam logic [11:0] A_TXCTL = {uth_pkg::IDX_TXCTL, 2'h0};
  localparam logic [11:0] A_MAXP = {uth_pkg::IDX_MAXP, 2'h0};
  localparam logic [11:0] A_STAT = {uth_pkg::IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] A_EN = {uth_pkg::IDX_IRQ_EN, 2'h0};
  localparam logic [11:0] A_CLR = {uth_pkg::IDX_IRQ_CLR, 2'h0};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fifo_byte_load, pkt_acked, dma_pkt_done, dma_xfer_done;
  logic tx_packet_ready, fifo_flush, dma_req, dir_tx, data_toggle, irq;
  logic [3:0] load_cnt = 4'h0;
  logic load_go = 1'h0;
  logic ack_en = 1'h0;
  logic ack_slow = 1'h0;
  logic [1:0] dma_cmd = 2'h0;
  logic [31:0] rd;
  logic err, tg;
  logic [7:0] w;
  logic [3:0] n;
  int cmp_count = 0;
  int miscompares = 0;
  uth_ctrl_high uth_ctrl_high_i (.*);
  uth_far_end uth_far_end_i (.*);
  // Free-running system clock
  always #12.5 clk = ~clk;
  // Readback of the high byte: bits 6, 3 and 1 always read zero
  function automatic logic [31:0] cexp(input logic [7:0] v, input logic t);
    return {24'h0, v & 8'hb4 | {7'h0, t}};
  endfunction : cexp
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One APB transfer; the answer is awaited, never assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (k = 0; k < 16 && pready !== 1'h1; k++) @(posedge clk);
    if (k == 16) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic wait_rdy(input logic v);
    int k;
    for (k = 0; k < 40 && tx_packet_ready !== v; k++) @(negedge clk);
    if (k == 40) begin
      miscompares++;
      summarize();
    end
  endtask : wait_rdy
  task automatic load(input logic [3:0] c);
    @(posedge clk);
    load_cnt <= c;
    load_go <= 1'h1;
    @(posedge clk);
    load_go <= 1'h0;
    settle(12);
  endtask : load
  task automatic dma(input logic [1:0] c);
    @(posedge clk);
    dma_cmd <= c;
    @(posedge clk);
    dma_cmd <= 2'h0;
    settle(3);
  endtask : dma
  initial begin
    void'($urandom(72));
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    settle(1);
    `CHK({dir_tx, data_toggle, tx_packet_ready, dma_req, irq}, 5'h10)
    apb(1'h0, A_CSRH, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, A_MAXP, 32'h0);
    `CHK(rd, {21'h0, uth_pkg::MAXP_RST})
    apb(1'h0, 12'h7fc, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    // All bits set except force; DMA request follows its enable
    apb(1'h1, A_CSRH, 32'hf7);
    settle(2);
    `CHK(dma_req, 1'h1)
    tg = 1'h1;
    apb(1'h0, A_CSRH, 32'h0);
    `CHK(rd, cexp(8'hf7, tg))
    apb(1'h1, A_CSRH, 32'ha4);
    settle(2);
    `CHK(dma_req, 1'h0)
    // Random toggle writes, some without the write enable
    repeat (6) begin
      w = 8'ha4 | (8'($urandom) & 8'h03);
      apb(1'h1, A_CSRH, {24'h0, w});
      if (w[1]) tg = w[0];
      apb(1'h0, A_CSRH, 32'h0);
      `CHK(rd, cexp(w, tg))
    end
    // Direction counts only once the FIFO is shared
    apb(1'h1, A_CSRH, 32'h84);
    settle(2);
    `CHK(dir_tx, 1'h1)
    apb(1'h1, A_TXCTL, 32'h2);
    settle(2);
    `CHK(dir_tx, 1'h0)
    apb(1'h1, A_CSRH, 32'ha4);
    settle(2);
    `CHK(dir_tx, 1'h1)
    // Short packet stays unready; the last byte makes it full
    n = 4'h2 + 4'($urandom % 6);
    apb(1'h1, A_MAXP, {28'h0, n});
    apb(1'h1, A_EN, 32'h7);
    load(n - 4'h1);
    `CHK(tx_packet_ready, 1'h0)
    load(4'h1);
    `CHK(tx_packet_ready, 1'h1)
    @(posedge clk);
    ack_slow <= 1'h1;
    ack_en <= 1'h1;
    wait_rdy(1'h0);
    tg = ~tg;
    apb(1'h0, A_CSRH, 32'h0);
    `CHK(rd, cexp(8'ha4, tg))
    apb(1'h0, A_STAT, 32'h0);
    `CHK({irq, rd}, 33'h1_0000_0001)
    apb(1'h1, A_EN, 32'h0);
    settle(1);
    `CHK(irq, 1'h0)
    apb(1'h1, A_CLR, 32'h7);
    apb(1'h1, A_EN, 32'h7);
    apb(1'h0, A_STAT, 32'h0);
    `CHK({irq, rd}, 33'h0)
    // Manual ready blocks DMA; force flip drops the packet
    ack_en <= 1'h0;
    apb(1'h1, A_TXCTL, 32'h3);
    wait_rdy(1'h1);
    apb(1'h1, A_CSRH, 32'hb4);
    settle(2);
    `CHK(dma_req, 1'h0)
    apb(1'h1, A_CSRH, 32'hbc);
    wait_rdy(1'h0);
    tg = ~tg;
    apb(1'h0, A_CSRH, 32'h0);
    `CHK(rd, cexp(8'hb4, tg))
    apb(1'h0, A_STAT, 32'h0);
    `CHK(rd, 32'h4)
    // Interrupt mode picks packet or whole-transfer events
    apb(1'h1, A_CSRH, 32'ha4);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, A_CLR, 32'h7);
      if (i == 2) apb(1'h1, A_CSRH, 32'ha0);
      dma(i == 1 ? 2'h2 : 2'h1);
      apb(1'h0, A_STAT, 32'h0);
      `CHK(rd, i == 0 ? 32'h0 : 32'h2)
    end
    summarize();
  end
endmodule : uth_ctrl_high_tb_top

// ==== test/uth_far_end.sv ====
// Far-end model: FIFO loader, bus acknowledger and DMA engine.
// Assumes bench commands change just after rising edges.
module uth_far_end (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_packet_ready,
  input wire logic [3:0] load_cnt,
  input wire logic load_go,
  input wire logic ack_en,
  input wire logic ack_slow,
  input wire logic [1:0] dma_cmd,
  output logic fifo_byte_load,
  output logic pkt_acked,
  output logic dma_pkt_done,
  output logic dma_xfer_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] left_r;
  logic [1:0] wait_r;
  // Bytes go back to back; one ack per ready packet, so no double count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 4'h0;
      wait_r <= 2'h0;
      fifo_byte_load <= 1'h0;
      pkt_acked <= 1'h0;
      dma_pkt_done <= 1'h0;
      dma_xfer_done <= 1'h0;
    end else begin
      left_r <= load_go ? load_cnt : left_r - 4'(left_r != 4'h0);
      fifo_byte_load <= left_r != 4'h0;
      pkt_acked <= ack_en && tx_packet_ready && wait_r == 2'h0 && !pkt_acked;
      if (!tx_packet_ready || pkt_acked) begin
        wait_r <= ack_slow ? 2'h3 : 2'h0; // Slow answer stalls the ack
      end else if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end
      dma_pkt_done <= dma_cmd[0];
      dma_xfer_done <= dma_cmd[1];
    end
  end
endmodule : uth_far_end
